// file: rtl/bwp_port_io.sv
/*
 * Four byte-wide general purpose ports with output latches, pin read-back,
 * read-modify-write latch reads, push-pull or open-drain drive and pull-ups.
 * Assumes the core flags read-modify-write accesses, the crossbar supplies
 * pin ownership, and drive configuration and pull-up disable come from
 * neighbouring registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bwp_port_io #(
    parameter int NPORT = bwp_pkg::NUM_PORTS,
    parameter logic [NPORT-1:0] PORT_PINNED = '1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Special register space access.
    input wire bwp_pkg::bwp_req_s req,
    output logic [7:0] rd_data_r,
    output logic rd_bit_r,
    output logic rd_hit_r,
    // Pin side.
    input wire logic [NPORT*8-1:0] pin_in,
    output logic [NPORT*8-1:0] pin_out_r,
    output logic [NPORT*8-1:0] pin_oe_r,
    output logic [NPORT*8-1:0] pin_pullup_r,
    // Neighbouring configuration.
    input wire logic [NPORT*8-1:0] pin_drive_config,
    input wire logic [NPORT*8-1:0] pin_xbar_own,
    input wire logic pullup_disable
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    // Returns a hit flag and the port index for a byte address.
    function automatic logic [2:0] port_dec(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int p = 0; p < NPORT; p++) begin
            if (a == bwp_pkg::PORT_OFS[p]) begin
                r = {1'b1, 2'(p)};
            end
        end
        return r;
    endfunction

    logic [2:0] byte_dec;
    logic [2:0] bit_dec;
    logic [2:0] bit_sel;

    // Bit addresses share the decode of the byte that holds them.
    assign byte_dec = port_dec(req.addr);
    assign bit_dec = port_dec({req.addr[7:3], 3'h0});
    assign bit_sel = req.addr[bwp_pkg::BIT_SEL_LSB +: bwp_pkg::BIT_SEL_W];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.

    logic [NPORT*8-1:0] sync1_r;
    logic [NPORT*8-1:0] sync2_r;

    // Pins are asynchronous, so two flops stand before any read path.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_r <= {(NPORT*8){bwp_pkg::SYNC_RESET}};
            sync2_r <= {(NPORT*8){bwp_pkg::SYNC_RESET}};
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latches and read path.

    logic [NPORT-1:0][7:0] latch_r;
    logic [NPORT-1:0][7:0] latch_nxt;
    logic [NPORT-1:0][7:0] pin_view;
    logic [7:0] rd_data_nxt;
    logic rd_bit_nxt;
    logic rd_hit_nxt;
    logic [7:0] cur;

    // An unbonded port has no pin, so its read returns the latch instead.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            pin_view[p] = PORT_PINNED[p] ? sync2_r[p*8 +: 8] : latch_r[p];
        end
    end

    // Byte writes and bit writes update one latch; reads choose pin or latch.
    always_comb begin
        latch_nxt = latch_r;
        rd_data_nxt = 8'h00;
        rd_bit_nxt = 1'b0;
        rd_hit_nxt = 1'b0;
        cur = 8'h00;
        if (req.bit_op) begin
            if (bit_dec[2]) begin
                // The rmw flag covers JBC, CPL bit and MOV/CLR/SET bit targets.
                cur = req.rmw ? latch_r[bit_dec[1:0]] : pin_view[bit_dec[1:0]];
                if (req.rd) begin
                    rd_bit_nxt = cur[bit_sel];
                    rd_hit_nxt = 1'b1;
                end
                if (req.wr) begin
                    latch_nxt[bit_dec[1:0]][bit_sel] = req.wbit;
                end
            end
        end else if (byte_dec[2]) begin
            // Logic, increment, decrement and DJNZ forms arrive with rmw set.
            cur = req.rmw ? latch_r[byte_dec[1:0]] : pin_view[byte_dec[1:0]];
            if (req.rd) begin
                rd_data_nxt = cur;
                rd_hit_nxt = 1'b1;
            end
            if (req.wr) begin
                latch_nxt[byte_dec[1:0]] = req.wdata;
            end
        end
    end

    // Registers stay usable whether or not the port is bonded out.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            latch_r <= {NPORT{bwp_pkg::PORT_DATA_RESET}};
            rd_data_r <= 8'h00;
            rd_bit_r <= 1'b0;
            rd_hit_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
            rd_data_r <= rd_data_nxt;
            rd_bit_r <= rd_bit_nxt;
            rd_hit_r <= rd_hit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    logic [NPORT*8-1:0] out_nxt;
    logic [NPORT*8-1:0] oe_nxt;
    logic [NPORT*8-1:0] pullup_nxt;

    // Enables are built from the next latch value so pins move with the write.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            out_nxt[p*8 +: 8] = latch_nxt[p];
            // On an owned, bonded pin a low always drives; a high drives only in push-pull mode.
            oe_nxt[p*8 +: 8] = PORT_PINNED[p]
                ? (pin_xbar_own[p*8 +: 8] & (~latch_nxt[p] | pin_drive_config[p*8 +: 8]))
                : 8'h00;
        end
        pullup_nxt = {(NPORT*8){~pullup_disable}};
    end

    // Pull-ups come up enabled so no driver floats before software acts.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_out_r <= {NPORT{bwp_pkg::PORT_DATA_RESET}};
            pin_oe_r <= '0;
            pin_pullup_r <= {(NPORT*8){bwp_pkg::PULLUP_RESET}};
        end else begin
            pin_out_r <= out_nxt;
            pin_oe_r <= oe_nxt;
            pin_pullup_r <= pullup_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic byte_wr0;
    logic byte_rd0;
    logic bit_acc0;

    assign byte_wr0 = req.wr && !req.bit_op && req.addr == bwp_pkg::PORT_ZERO_DATA_OFS;
    assign byte_rd0 = req.rd && !req.bit_op && req.addr == bwp_pkg::PORT_ZERO_DATA_OFS;
    assign bit_acc0 = req.bit_op && req.addr[7:3] == bwp_pkg::PORT_ZERO_DATA_OFS[7:3];

    latch_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        byte_wr0 |=> pin_out_r[7:0] == $past(req.wdata))
        else $error("Port zero latch missed a byte write.");

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !req.wr [*2] |-> $stable(pin_out_r))
        else $error("Port output changed without a write.");

    pin_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        byte_rd0 && !req.rmw && PORT_PINNED[0]
        |=> rd_hit_r && rd_data_r == $past(sync2_r[7:0]))
        else $error("Plain read did not return pin levels.");

    rmw_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        byte_rd0 && req.rmw |=> rd_data_r == $past(latch_r[0]))
        else $error("Read-modify-write read did not return the latch.");

    bit_rmw_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bit_acc0 && req.rd && req.rmw |=> rd_bit_r == $past(latch_r[0][bit_sel]))
        else $error("Bit read-modify-write did not use the latch.");

    bit_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bit_acc0 && req.wr |=> pin_out_r[$past(bit_sel)] == $past(req.wbit))
        else $error("Bit write did not reach the latch.");

    drive_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !pin_out_r[0] && $past(pin_xbar_own[0]) && PORT_PINNED[0] |-> pin_oe_r[0])
        else $error("Owned pin with latch zero is not driven low.");

    open_drain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_out_r[0] && !$past(pin_drive_config[0]) |-> !pin_oe_r[0])
        else $error("Open-drain pin drove a high level.");

    pullup_reset_a: assert property (@(posedge clk_sys)
        sys_rst |=> (&pin_pullup_r) && (pin_oe_r == '0))
        else $error("Pull-ups not enabled after reset.");

    ////////////////////////////////////////////////////////////////////////////
    // Read path checks.

    // A byte read that decodes to a port always answers on the next cycle.
    byte_hit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && !req.bit_op && byte_dec[2] |=> rd_hit_r)
        else $error("Byte read of a port gave no hit.");

    // Unmapped byte addresses must not answer, or the core would take stray data.
    unmapped_miss_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && !req.bit_op && !byte_dec[2] |=> !rd_hit_r && rd_data_r == 8'h00)
        else $error("Unmapped byte read was answered.");

    // Unmapped bit addresses behave the same way as unmapped bytes.
    bit_miss_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && req.bit_op && !bit_dec[2] |=> !rd_hit_r && !rd_bit_r)
        else $error("Unmapped bit read was answered.");

    // Read outputs stand for one cycle only, then fall back to zero.
    read_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !req.rd |=> !rd_hit_r && !rd_bit_r && rd_data_r == 8'h00)
        else $error("Read outputs set without a read.");

    // A plain bit read of a bonded port reports the synchronised pin, not the latch.
    bit_pin_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bit_acc0 && req.rd && !req.rmw && PORT_PINNED[0]
        |=> rd_hit_r && rd_bit_r == $past(sync2_r[bit_sel]))
        else $error("Plain bit read did not return the pin level.");

    // The core's combined step reads the old latch while the new value lands.
    rmw_combined_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        byte_rd0 && byte_wr0 && req.rmw
        |=> rd_data_r == $past(latch_r[0]) && pin_out_r[7:0] == $past(req.wdata))
        else $error("Combined read-modify-write step lost a value.");

    ////////////////////////////////////////////////////////////////////////////
    // Latch and driver checks.

    // A byte write to port zero must leave every other port untouched.
    other_ports_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        byte_wr0 |=> pin_out_r[NPORT*8-1:8] == $past(pin_out_r[NPORT*8-1:8]))
        else $error("Byte write disturbed another port.");

    // A bit write changes only its own bit; neighbours keep the latch value.
    bit_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bit_acc0 && req.wr
        |=> ((pin_out_r[7:0] ^ $past(latch_r[0])) & ~(8'h01 << $past(bit_sel))) == 8'h00)
        else $error("Bit write disturbed a neighbouring bit.");

    // A pin the crossbar keeps for another signal is never driven by the port.
    not_owned_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(pin_xbar_own[0]) |-> !pin_oe_r[0])
        else $error("Port drove a pin it does not own.");

    // Push-pull drives a high level; the reset guard skips the cleared enables.
    push_pull_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) && pin_out_r[0] && $past(pin_drive_config[0])
        && $past(pin_xbar_own[0]) && PORT_PINNED[0] |-> pin_oe_r[0])
        else $error("Push-pull pin did not drive a high level.");

    // The highest port is the one a reduced package drops first.
    unbonded_oe_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !PORT_PINNED[NPORT-1] |-> pin_oe_r[NPORT*8-1 -: 8] == 8'h00)
        else $error("Unbonded port enabled a driver.");

    // Pull-ups follow the disable input one cycle later once out of reset.
    pullup_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) |-> pin_pullup_r == {(NPORT*8){!$past(pullup_disable)}})
        else $error("Pull-ups did not follow the disable input.");

endmodule

`default_nettype wire

// file: rtl/bwp_pkg.sv
/*
 * Package for the byte-wide general purpose port block: register offsets,
 * reset values, widths and the bus request carrier.
 * Assumes the processor presents one special register access per cycle.
 */
package bwp_pkg;

    localparam int NUM_PORTS = 4;
    localparam int PORT_WIDTH = 8;

    // Byte addresses of the port data registers in the special register space.
    localparam logic [7:0] PORT_ZERO_DATA_OFS = 8'h80;
    localparam logic [7:0] PORT_ONE_DATA_OFS = 8'h90;
    localparam logic [7:0] PORT_TWO_DATA_OFS = 8'hA0;
    localparam logic [7:0] PORT_THREE_DATA_OFS = 8'hB0;
    localparam logic [3:0][7:0] PORT_OFS = {PORT_THREE_DATA_OFS, PORT_TWO_DATA_OFS,
                                            PORT_ONE_DATA_OFS, PORT_ZERO_DATA_OFS};

    // A bit address holds the owning byte address in its upper five bits.
    localparam int BIT_SEL_LSB = 0;
    localparam int BIT_SEL_W = 3;

    // Values after reset.
    localparam logic [7:0] PORT_DATA_RESET = 8'hFF;
    localparam logic SYNC_RESET = 1'b1;
    localparam logic PULLUP_RESET = 1'b1;

    // One access from the processor; bit_op selects bit addressing of addr.
    typedef struct packed {
        logic rd;
        logic wr;
        logic rmw;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wbit;
    } bwp_req_s;

endpackage

// file: tb/bwp_pin_model.sv
/*
 * Board-side pin model for the port block: resolves each pin level.
 * Assumes one system clock and a board driver per pin that the bench controls.
 */
`timescale 1ns/1ps
`default_nettype none

module bwp_pin_model (
    // Clock.
    input wire logic clk_sys,
    // Block side.
    input wire logic [31:0] pin_out_r,
    input wire logic [31:0] pin_oe_r,
    input wire logic [31:0] pin_pullup_r,
    // Board side.
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    logic [31:0] flt_r = 32'h0;

    // A floating pin wanders each cycle, so a read of it never looks steady.
    always @(posedge clk_sys) begin
        flt_r <= ~flt_r;
    end

    // Block drive wins, then the board driver, then the weak pull-up.
    assign pin_in = (pin_oe_r & pin_out_r) |
        (~pin_oe_r & ext_en & ext_val) | (~pin_oe_r & ~ext_en & (pin_pullup_r | flt_r));
endmodule

`default_nettype wire

// file: tb/test_byte_wide_port_io.sv
/*
 * Self-checking bench for the port block with port three left unbonded.
 * Assumes the pin model resolves pin levels and a 100 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_byte_wide_port_io;
    typedef struct packed {
        logic [7:0] addr, wdata, own, ext, exp;
    } bwp_row_s;
    logic clk_sys = 1'b0, sys_rst = 1'b1, pud = 1'b0, rd_bit_r, rd_hit_r;
    bwp_pkg::bwp_req_s req = '0;
    logic [7:0] rd_data_r;
    logic [31:0] pin_in, pin_out_r, pin_oe_r, pin_pullup_r, ext_val = '0;
    logic [31:0] cfg = '1, own = '0, ext_en = '1;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    // Expected plain read mixes latch bits on owned pins with board levels elsewhere, but is the whole latch on unbonded port three.
    bwp_row_s rows [4] = '{'{8'h80, 8'h55, 8'hFF, 8'h00, 8'h55}, '{8'h90, 8'hA3, 8'h00,
        8'h3C, 8'h3C}, '{8'hA0, 8'h0F, 8'hF0, 8'h5A, 8'h0A}, '{8'hB0, 8'hC6, 8'h00,
        8'h00, 8'hC6}};

    always #5 clk_sys = ~clk_sys;

    bwp_port_io #(.PORT_PINNED(4'h7)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .req(req), .rd_data_r(rd_data_r), .rd_bit_r(rd_bit_r), .rd_hit_r(rd_hit_r),
        .pin_in(pin_in), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
        .pin_pullup_r(pin_pullup_r), .pin_drive_config(cfg), .pin_xbar_own(own),
        .pullup_disable(pud));
    bwp_pin_model pins (.clk_sys(clk_sys), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
        .pin_pullup_r(pin_pullup_r), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    // One access: strobe for one edge, outputs sampled just after the answer edge.
    task automatic acc(input logic rd, wr, rmw, bo, input logic [7:0] a, wd,
                       input logic wb);
        @(posedge clk_sys);
        req <= '{rd, wr, rmw, bo, a, wd, wb};
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // A hang is cut short well past the roughly 90 cycles the run needs.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Each row writes a port, then reads pins and latch apart.
        foreach (rows[i]) begin
            @(posedge clk_sys);
            own[i*8 +: 8] <= rows[i].own;
            ext_en[i*8 +: 8] <= ~rows[i].own;
            ext_val[i*8 +: 8] <= rows[i].ext;
            acc(0, 1, 0, 0, rows[i].addr, rows[i].wdata, 0);
            repeat (4) @(posedge clk_sys);
            acc(1, 0, 0, 0, rows[i].addr, 8'h00, 0);
            `CHK(rd_data_r, rows[i].exp)
            `CHK(rd_hit_r, 1'b1)
            acc(1, 0, 1, 0, rows[i].addr, 8'h00, 0);
            `CHK(rd_data_r, rows[i].wdata)
            $display("row %0d done", i);
        end
        // Second reset: latches high, drivers off, pull-ups on.
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(pin_out_r, 32'hFFFFFFFF)
        `CHK(pin_oe_r, 32'h00000000)
        `CHK(pin_pullup_r, 32'hFFFFFFFF)
        sys_rst <= 1'b0;
        acc(1, 0, 1, 0, 8'h90, 8'h00, 0);
        `CHK(rd_data_r, 8'hFF)
        $display("reset test done");
        // Open-drain port zero: ones float up on the pull-up, zeros are driven.
        cfg[7:0] <= 8'h00;
        own[7:0] <= 8'hFF;
        ext_en[7:0] <= 8'h00;
        acc(0, 1, 0, 0, 8'h80, 8'hF0, 0);
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(pin_oe_r[7:0], 8'h0F)
        acc(1, 0, 0, 0, 8'h80, 8'h00, 0);
        `CHK(rd_data_r, 8'hF0)
        $display("open-drain test done");
        // Bit write, bit latch read, then an unmapped read that must miss.
        acc(0, 1, 1, 1, 8'h84, 8'h00, 0);
        `CHK(pin_out_r[7:0], 8'hE0)
        acc(1, 0, 1, 1, 8'h85, 8'h00, 0);
        `CHK(rd_bit_r, 1'b1)
        acc(1, 0, 0, 0, 8'h81, 8'h00, 0);
        `CHK(rd_hit_r, 1'b0)
        acc(1, 0, 0, 1, 8'h84, 8'h00, 0);
        `CHK(rd_bit_r, 1'b0)
        acc(1, 1, 1, 0, 8'h90, 8'h5A, 0);
        `CHK(rd_data_r, 8'hFF)
        `CHK(pin_out_r[15:8], 8'h5A)
        pud <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(pin_pullup_r, 32'h00000000)
        $display("bit and pull-up test done");
        print_verdict();
    end
endmodule

`default_nettype wire
